// >>> pkg/bsr_pkg.sv
package bsr_pkg;
  // ****************************************************************
  // Command framing
  // ****************************************************************
  localparam int START_LEN = 3;
  localparam int SETUP_LEN = 4;
  localparam int STOP_LEN = 3;
  localparam int CMD_LEN = 10;
  localparam int WORD_LEN = 16;
  localparam int READ_CLKS = 17;
  localparam int ACK_CLKS = 2;
  localparam int RESET_LEN = 21;
  localparam logic [2:0] START_BITS = 3'h7;
  localparam logic [2:0] STOP_BITS = 3'h0;
  // Setup codes and reset pattern: neutral values of our own
  localparam logic [3:0] CODE_PRESS = 4'hA;
  localparam logic [3:0] CODE_TEMP = 4'h9;
  localparam logic [3:0] CODE_CAL1 = 4'h5;
  localparam logic [3:0] CODE_CAL2 = 4'h6;
  localparam logic [3:0] CODE_CAL3 = 4'h3;
  localparam logic [3:0] CODE_CAL4 = 4'hC;
  localparam logic [20:0] RESET_PATTERN = 21'h155540;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int CONV_MS = 35;
  localparam int CONV_CYCLES = CONV_MS * CLK_MHZ * 1000;
  localparam int SCLK_DIV = 8;
  localparam int RESET_DOUT_QUIET = 0;
endpackage

// >>> pkg/bsr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bsr_if;
  logic serial_clock;
  logic serial_in;
  logic serial_out;
  modport device (input serial_clock, input serial_in, output serial_out);
  modport host (output serial_clock, output serial_in, input serial_out);
endinterface
`default_nettype wire

// >>> hdl/bsr_device.sv
`timescale 1ns/1ps
`default_nettype none
// What the link asks of this block and its host
// R1: Sample input, launch output on rising clock
// R2: Host samples and drives on falling edge
// R3: Only the host makes serial clock
// R4: Output carries result, calibration, or status
// R5: Three high bits start each command
// R6: Four-bit setup selects the operation
// R7: Three low bits stop each command
// R8: Acknowledge rises during last stop bit
// R9: Host gives two clocks after acknowledge
// R10: Clock held low; falling output marks done
// R11: Host gives seventeen clocks to read result
// R12: Readout pauses and resumes on held clock
// R13: Host reads result before next conversion
// R14: Reset pattern resynchronises from any state
// R15: Host ignores output during reset pattern
// R16: Host sends reset before each conversion
// R17: Four readable sixteen-bit calibration words
// R18: Shared converter yields pressure or temperature
// R19: Host reads calibration once after reset
// R20: Master clock may stop in standby
// R21: Setup codes and reset pattern are parameters
// R22: Return idle with output low after transfer
module bsr_device
  import bsr_pkg::*;
#(
  parameter int CONV_COUNT = CONV_CYCLES,
  parameter logic [15:0] CAL_FIRST = 16'h1234,
  parameter logic [15:0] CAL_SECOND = 16'h5678,
  parameter logic [15:0] CAL_THIRD = 16'h9ABC,
  parameter logic [15:0] CAL_FOURTH = 16'hDEF0
) (
  input wire logic CLK,
  input wire logic RST,
  bsr_if.device LINK,
  input wire logic [15:0] PRESSURE_SAMPLE,
  input wire logic [15:0] TEMPERATURE_SAMPLE,
  output logic BUSY,
  output logic [15:0] LAST_RESULT
);
  // ****************************************************************
  // Pin synchronisers and edge detect
  // ****************************************************************
  typedef enum {
    ST_START, ST_SETUP, ST_STOP, ST_ACK,
    ST_CONV, ST_WAIT, ST_READ, ST_TAIL
  } bsr_state_t;
  logic [1:0] clk_sync;
  logic [1:0] din_sync;
  logic clk_prev;
  // Both pins pass the same two flops, so clock and data stay aligned
  // Edge flags read only the second flop and its delayed copy
  wire rise = clk_sync[1] & ~clk_prev;
  wire fall = ~clk_sync[1] & clk_prev;
  wire din = din_sync[1];
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      clk_sync <= 2'h0;
      din_sync <= 2'h0;
      clk_prev <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], LINK.serial_clock};
      din_sync <= {din_sync[0], LINK.serial_in};
      clk_prev <= clk_sync[1];
    end
  end
  // ****************************************************************
  // Setup code decode
  // ****************************************************************
  function automatic logic code_is_conv(input logic [3:0] c);
    return (c == CODE_PRESS) || (c == CODE_TEMP);
  endfunction
  function automatic logic code_is_cal(input logic [3:0] c);
    return (c == CODE_CAL1) || (c == CODE_CAL2) || (c == CODE_CAL3) || (c == CODE_CAL4);
  endfunction
  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  bsr_state_t state;
  logic [4:0] cnt;
  logic [3:0] setup;
  logic [20:0] hist;
  logic [16:0] shreg;
  logic [31:0] conv_cnt;
  logic is_press;
  logic dout;
  wire [20:0] next_hist = {hist[19:0], din};
  // The pattern is watched in every state, so a lost frame always recovers
  wire reset_seen = rise && (next_hist == RESET_PATTERN); // R14 R21
  wire [3:0] next_setup = {setup[2:0], din};
  wire is_conv = code_is_conv(setup);
  // Unknown codes fall back to idle so a corrupt setup starts nothing
  wire known = is_conv || code_is_cal(setup); // R6
  // Calibration words are fixed at build time; no write path exists
  wire [15:0] cal_word = (setup == CODE_CAL1) ? CAL_FIRST :
    (setup == CODE_CAL2) ? CAL_SECOND :
    (setup == CODE_CAL3) ? CAL_THIRD : CAL_FOURTH; // R17
  wire [15:0] sample = is_press ? PRESSURE_SAMPLE : TEMPERATURE_SAMPLE; // R18
  assign LINK.serial_out = dout;
  // ****************************************************************
  // Reset pattern watch
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hist <= 21'h000000;
    end else if (rise) begin
      hist <= next_hist;
    end
  end
  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= ST_START;
      cnt <= 5'h00;
      setup <= 4'h0;
      shreg <= 17'h00000;
      conv_cnt <= 32'h0;
      is_press <= 1'b0;
      dout <= 1'b0;
      BUSY <= 1'b0;
      LAST_RESULT <= 16'h0000;
    end else begin
      if (reset_seen) begin // R14 R15
        state <= ST_START;
        cnt <= 5'h00;
        dout <= 1'b0;
        BUSY <= 1'b0;
      end else unique case (state)
        ST_START: if (rise) begin // R5
          if (din) cnt <= cnt + 5'h01;
          else cnt <= 5'h00;
          if (din && cnt == 5'(START_LEN - 1)) begin
            state <= ST_SETUP;
            cnt <= 5'h00;
          end
        end
        ST_SETUP: if (rise) begin // R6
          setup <= next_setup;
          cnt <= cnt + 5'h01;
          if (cnt == 5'(SETUP_LEN - 1)) begin
            state <= ST_STOP;
            cnt <= 5'h00;
          end
        end
        // A high bit inside the stop field breaks the frame
        ST_STOP: if (rise) begin // R7
          cnt <= cnt + 5'h01;
          if (din) begin
            state <= ST_START;
            cnt <= 5'h00;
          end else if (cnt == 5'(STOP_LEN - 1)) begin
            cnt <= 5'h00;
            if (!known) state <= ST_START;
            else if (is_conv) begin
              dout <= 1'b1; // R8 R1
              is_press <= (setup == CODE_PRESS);
              state <= ST_ACK;
            end else begin
              shreg <= {1'b0, cal_word}; // R4
              state <= ST_READ;
            end
          end
        end
        ST_ACK: if (rise) begin // R9
          cnt <= cnt + 5'h01;
          if (cnt == 5'(ACK_CLKS - 1)) begin
            state <= ST_CONV;
            conv_cnt <= 32'h0;
            BUSY <= 1'b1;
          end
        end
        // Counted in system clocks; the host holds the link clock low meanwhile
        ST_CONV: begin
          conv_cnt <= conv_cnt + 32'h1;
          if (conv_cnt == 32'(CONV_COUNT - 1)) begin
            dout <= 1'b0; // R10
            BUSY <= 1'b0;
            // Dummy bit first, then the word with its top bit leading
            shreg <= {1'b0, sample};
            LAST_RESULT <= sample;
            cnt <= 5'h00;
            state <= ST_WAIT;
          end
        end
        // One spare cycle so the completion edge settles before readout
        ST_WAIT: state <= ST_READ;
        ST_READ: if (rise) begin // R12 R1
          dout <= shreg[16];
          shreg <= {shreg[15:0], 1'b0};
          cnt <= cnt + 5'h01;
          if (cnt == 5'(READ_CLKS - 1)) begin
            cnt <= 5'h00;
            state <= ST_TAIL;
          end
        end
        // The last bit must stand until the host has sampled it on its falling edge
        ST_TAIL: if (fall) begin // R22
          dout <= 1'b0;
          state <= ST_START;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> hdl/bsr_host.sv
`timescale 1ns/1ps
`default_nettype none
module bsr_host
  import bsr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  bsr_if.host LINK,
  input wire logic CMD_VALID,
  input wire logic [3:0] CMD_CODE,
  input wire logic CMD_RESET,
  output logic CMD_READY,
  output logic DONE,
  output logic [15:0] DATA
);
  // ****************************************************************
  // Clock divider and serial sequencer
  // ****************************************************************
  typedef enum {HS_IDLE, HS_SEND, HS_WAIT, HS_READ} bsr_hstate_t;
  bsr_hstate_t state;
  logic [1:0] dout_sync;
  logic [3:0] div;
  logic sclk;
  logic sdi;
  logic [20:0] sh;
  logic [5:0] left;
  logic conv;
  logic reading;
  logic [4:0] rcnt;
  wire half = (div == 4'(SCLK_DIV - 1));
  wire dout = dout_sync[1];
  wire is_conv = (CMD_CODE == CODE_PRESS) || (CMD_CODE == CODE_TEMP);
  assign LINK.serial_clock = sclk; // R3
  assign LINK.serial_in = sdi;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= HS_IDLE;
      dout_sync <= 2'h0;
      div <= 4'h0;
      sclk <= 1'b0;
      sdi <= 1'b0;
      sh <= 21'h000000;
      left <= 6'h00;
      conv <= 1'b0;
      reading <= 1'b0;
      rcnt <= 5'h00;
      CMD_READY <= 1'b0;
      DONE <= 1'b0;
      DATA <= 16'h0000;
    end else begin
      dout_sync <= {dout_sync[0], LINK.serial_out};
      DONE <= 1'b0;
      div <= half ? 4'h0 : div + 4'h1;
      unique case (state)
        HS_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_RESET) begin // R16
            // First bit goes out now, so the first rising edge already samples it
            sdi <= RESET_PATTERN[20];
            sh <= {RESET_PATTERN[19:0], 1'b0};
            left <= 6'(RESET_LEN);
            conv <= 1'b0;
            reading <= 1'b0;
            CMD_READY <= 1'b0;
            state <= HS_SEND;
          end else if (CMD_VALID) begin // R5 R6 R7
            sdi <= START_BITS[2];
            sh <= {START_BITS[1:0], CMD_CODE, STOP_BITS, 12'h000};
            left <= is_conv ? 6'(CMD_LEN + ACK_CLKS) : 6'(CMD_LEN + READ_CLKS);
            conv <= is_conv;
            reading <= ~is_conv;
            rcnt <= 5'h00;
            CMD_READY <= 1'b0;
            state <= HS_SEND;
          end
        end
        HS_SEND: if (half) begin
          sclk <= ~sclk;
          if (sclk) begin // Falling edge: drive and sample R2
            sdi <= sh[20];
            sh <= {sh[19:0], 1'b0};
            if (reading && rcnt != 5'h00) DATA <= {DATA[14:0], dout}; // R11
            if (left == 6'h00) begin
              sdi <= 1'b0;
              sclk <= 1'b0;
              if (reading) DONE <= 1'b1;
              state <= conv ? HS_WAIT : HS_IDLE; // R9 R10
            end
          end else begin
            left <= left - 6'h01;
            if (reading || left <= 6'(READ_CLKS)) rcnt <= rcnt + 5'h01;
          end
        end
        HS_WAIT: if (!dout) begin // R10 R13
          left <= 6'(READ_CLKS);
          reading <= 1'b1;
          conv <= 1'b0;
          rcnt <= 5'h00;
          state <= HS_SEND;
        end
        HS_READ: state <= HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> sim/bsr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bsr_chk
  import bsr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic serial_out
);
  // ****************
  // Frame capture
  // ****************
  logic [20:0] shreg;
  wire logic conv_hit;
  wire logic reset_hit;
  assign conv_hit = shreg[9:7] == START_BITS && shreg[2:0] == STOP_BITS
    && (shreg[6:3] == CODE_PRESS || shreg[6:3] == CODE_TEMP);
  assign reset_hit = shreg == RESET_PATTERN;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shreg <= '0;
    end else if ($rose(serial_clock)) begin
      shreg <= {shreg[19:0], serial_in};
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ****************
  // Link rules
  // ****************
  property p_sclk_high;
    $rose(serial_clock) |-> serial_clock [*8] ##1 !serial_clock;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("clock high phase");
  property p_sclk_low;
    $fell(serial_clock) |-> !serial_clock [*8];
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("clock low phase");
  property p_din_fall;
    $changed(serial_in) |-> !serial_clock;
  endproperty
  a_din_fall: assert property (p_din_fall) else $error("input moved high");
  property p_out_rise;
    $rose(serial_out) |-> serial_clock;
  endproperty
  a_out_rise: assert property (p_out_rise) else $error("output rose low");
  // Two sync flops leave at most four cycles from clock rise to launch
  property p_out_late;
    $changed(serial_out) && serial_clock |-> !$past(serial_clock, 5);
  endproperty
  a_out_late: assert property (p_out_late) else $error("late launch");
  property p_ack;
    $rose(conv_hit) |-> !serial_out ##[1:4] serial_out;
  endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge");
  property p_conv_done;
    (serial_out && !serial_clock) [*8] ##1 (serial_out && !serial_clock) ##1
      (serial_out && !serial_clock) |-> !serial_clock throughout (##[1:400] !serial_out);
  endproperty
  a_conv_done: assert property (p_conv_done) else $error("no completion");
  property p_resync;
    $rose(reset_hit) |-> ##[0:6] !serial_out;
  endproperty
  a_resync: assert property (p_resync) else $error("no resync");
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import bsr_pkg::*;
;
  // ****************
  // Bench wiring
  // ****************
  localparam logic [15:0] CW0 = 16'hA5C3;
  localparam logic [15:0] CW1 = 16'h0F1E;
  localparam logic [15:0] CW2 = 16'h8001;
  localparam logic [15:0] CW3 = 16'h7FFE;
  localparam logic [3:0] CODES [6] = '{CODE_PRESS, CODE_TEMP, CODE_CAL1, CODE_CAL2,
    CODE_CAL3, CODE_CAL4};
  logic clk, rst, hrst, cmd_valid, cmd_reset, cmd_ready, done, busy;
  logic [3:0] cmd_code, code;
  logic [15:0] data, last_result, psamp, tsamp;
  int n_fail, compares;
  wire logic host_rst;
  assign host_rst = rst | hrst;
  bsr_if link ();
  bsr_device #(.CONV_COUNT(200), .CAL_FIRST(CW0), .CAL_SECOND(CW1), .CAL_THIRD(CW2),
    .CAL_FOURTH(CW3)) bsr_device_inst (.CLK(clk), .RST(rst), .LINK(link.device),
    .PRESSURE_SAMPLE(psamp), .TEMPERATURE_SAMPLE(tsamp), .BUSY(busy),
    .LAST_RESULT(last_result));
  bsr_host bsr_host_inst (.CLK(clk), .RST(host_rst), .LINK(link.host),
    .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_RESET(cmd_reset),
    .CMD_READY(cmd_ready), .DONE(done), .DATA(data));
  bsr_chk bsr_chk_inst (.CLK(clk), .RST(host_rst), .serial_clock(link.serial_clock),
    .serial_in(link.serial_in), .serial_out(link.serial_out));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****************
  // Helpers
  // ****************
  function automatic logic [15:0] expect_word(input logic [3:0] c);
    case (c)
      CODE_PRESS: return psamp;
      CODE_TEMP: return tsamp;
      CODE_CAL1: return CW0;
      CODE_CAL2: return CW1;
      CODE_CAL3: return CW2;
      default: return CW3;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded so a stuck link ends the run instead of hanging it
  task automatic wait_for(input logic use_done);
    int k;
    logic seen;
    k = 0;
    seen = 1'b0;
    while ((use_done ? done : cmd_ready) !== 1'b1) begin
      seen |= busy === 1'b1;
      @(negedge clk);
      k++;
      if (k > 4000) begin
        n_fail++;
        tally_and_finish();
      end
    end
    if (use_done) begin
      cmp({15'h0, seen}, {15'h0, code == CODE_PRESS || code == CODE_TEMP});
    end
  endtask
  task automatic issue(input logic rst_only);
    wait_for(1'b0);
    // The device drops its line a few cycles after the host's last falling edge
    repeat (4) @(negedge clk);
    cmp({15'h0, link.serial_out}, 16'h0);
    cmd_code = code;
    cmd_reset = rst_only;
    cmd_valid = !rst_only;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_reset = 1'b0;
    if (!rst_only) begin
      wait_for(1'b1);
      cmp(data, expect_word(code));
      if (code == CODE_PRESS || code == CODE_TEMP) begin
        cmp(last_result, expect_word(code));
      end
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    rst = 1'b1;
    hrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_reset = 1'b0;
    cmd_code = 4'h0;
    code = 4'h0;
    psamp = 16'hFFFF;
    tsamp = 16'h0000;
    n_fail = 0;
    compares = 0;
    void'($urandom(32'hBEA1));
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      code = i < 6 ? CODES[i] : CODES[$urandom_range(5)];
      if (i > 1) begin
        psamp = 16'($urandom);
        tsamp = 16'($urandom);
      end
      if (code == CODE_PRESS || code == CODE_TEMP) begin
        issue(1'b1);
      end
      issue(1'b0);
      if (i == 8) begin
        // Host dropped mid-frame; only the reset pattern can recover the device
        code = CODE_TEMP;
        cmd_code = code;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        repeat (60) @(negedge clk);
        hrst = 1'b1;
        repeat (2) @(negedge clk);
        hrst = 1'b0;
        issue(1'b1);
        issue(1'b0);
      end
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
